/* File: design/acc_adc_ctrl.sv */
`timescale 1ns/10ps
module acc_adc_ctrl #(
	parameter int LANES = 4
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic extended_control_option,
	input wire logic [3:0] pinModeSel,
	input wire logic [LANES*8-1:0] sampleIn,
	acc_link_if.device link,
	output logic [1:0] adcMode,
	output logic [7:0] inputMap,
	output logic dcCoupled,
	output logic term150,
	output logic [15:0] apertureDelay,
	output logic [1:0] div4State,
	output logic [1:0] div4Count,
	output logic overRangeEn,
	output logic calActive
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] regs_q [acc_pkg::NUM_REGS];
	logic sclkD_q, syncD_q, taden_q;
	logic [3:0] coarse_q;
	logic [acc_pkg::FRAME_W-1:0] shift_q;
	logic [5:0] bitCnt_q;
	logic [15:0] rdShift_q;
	logic wrStrobe;
	logic [3:0] wrAddr;
	logic [15:0] wrData;
	logic sclkRise;
	logic calDone;
	logic [15:0] cfg, ser, sync;

	assign cfg = regs_q[acc_pkg::REG_CONFIG1];
	assign ser = regs_q[acc_pkg::REG_SERIAL];
	assign sync = regs_q[acc_pkg::REG_SYNC];
	assign sclkRise = link.sclk & ~sclkD_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclkD_q <= 1'b0;
		end else begin
			sclkD_q <= link.sclk;
		end
	end

	// ----------------------------------------
	// Serial frame: rw, addr, data, msb first
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
			bitCnt_q <= '0;
		end else if (link.scs) begin
			bitCnt_q <= '0;
		end else if (sclkRise) begin
			shift_q <= {shift_q[acc_pkg::FRAME_W-2:0], link.sdi};
			bitCnt_q <= bitCnt_q + 6'h01;
		end
	end

	always_comb begin
		wrStrobe = 1'b0;
		wrAddr = shift_q[acc_pkg::FRAME_W-3 -: 4];
		wrData = {shift_q[14:0], link.sdi};
		if (sclkRise && !link.scs && extended_control_option
			&& bitCnt_q == 6'(acc_pkg::FRAME_W - 1)
			&& !shift_q[acc_pkg::FRAME_W-2]) begin
			wrStrobe = 1'b1;
		end
	end

	// Readback shifted out after address
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdShift_q <= '0;
		end else if (sclkRise && !link.scs
			&& bitCnt_q == 6'(acc_pkg::ADDR_W)) begin
			rdShift_q <= regs_q[{shift_q[2:0], link.sdi}];
		end else if (sclkRise && !link.scs) begin
			rdShift_q <= {rdShift_q[14:0], 1'b0};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link.sdo <= 1'b0;
		end else begin
			link.sdo <= rdShift_q[15];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < acc_pkg::NUM_REGS; gi++) begin : gReg
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					regs_q[gi] <= (gi == int'(acc_pkg::REG_TPSEQ)) ?
						acc_pkg::TPSEQ_RESET : 16'h0000;
				end else if (wrStrobe && wrAddr == 4'(gi)) begin
					regs_q[gi] <= wrData;
				end else if (gi == int'(acc_pkg::REG_CONFIG1)
					&& calDone) begin
					regs_q[gi][acc_pkg::CFG_CAL_BIT] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Mode and mapping
	// ----------------------------------------
	logic [1:0] modeSrc;
	logic [7:0] sel;
	always_comb begin
		modeSrc = extended_control_option ? cfg[1:0] : pinModeSel[1:0];
		sel = cfg[9:2];
		case (acc_pkg::acc_mode_e'(modeSrc))
			acc_pkg::MODE_SINGLE: sel = {4{cfg[3:2]}};
			acc_pkg::MODE_DUAL: sel = {{2{cfg[5:4]}}, {2{cfg[3:2]}}};
			acc_pkg::MODE_QUAD: sel = cfg[9:2];
			default: sel = {4{cfg[3:2]}};
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			adcMode <= 2'h0;
			inputMap <= 8'h00;
			dcCoupled <= 1'b0;
			term150 <= 1'b0;
			apertureDelay <= 16'h0000;
			overRangeEn <= 1'b1;
		end else begin
			adcMode <= modeSrc;
			inputMap <= sel;
			dcCoupled <= cfg[acc_pkg::CFG_DC_BIT];
			term150 <= cfg[acc_pkg::CFG_TERM150_BIT];
			apertureDelay <= cfg[acc_pkg::CFG_TADEN_BIT] ?
				regs_q[acc_pkg::REG_APDELAY] : 16'h0000;
			overRangeEn <= ~ser[acc_pkg::SER_ORPD_BIT];
		end
	end

	// ----------------------------------------
	// Divide-by-four, bump and sync capture
	// ----------------------------------------
	logic bumpD_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div4Count <= 2'h0;
			bumpD_q <= 1'b0;
		end else begin
			bumpD_q <= sync[acc_pkg::SYNC_BUMP_BIT];
			if (!(sync[acc_pkg::SYNC_BUMP_BIT] && !bumpD_q)) begin
				div4Count <= div4Count + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncD_q <= 1'b0;
			div4State <= 2'h0;
		end else begin
			syncD_q <= link.syncIn;
			if (link.syncIn && !syncD_q && cfg[acc_pkg::CFG_SYNCEN_BIT]) begin
				div4State <= div4Count;
			end
		end
	end

	// ----------------------------------------
	// Calibration
	// ----------------------------------------
	logic [7:0] calCnt_q;
	assign calDone = calActive && calCnt_q == 8'h01;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			calCnt_q <= 8'(acc_pkg::CAL_CYCLES);
			calActive <= 1'b1;
		end else if (calActive) begin
			calCnt_q <= calCnt_q - 8'h01;
			calActive <= calCnt_q != 8'h01;
		end else if (cfg[acc_pkg::CFG_CAL_BIT]) begin
			calCnt_q <= 8'(acc_pkg::CAL_CYCLES);
			calActive <= 1'b1;
		end
	end

	// ----------------------------------------
	// Lanes: data, test modes, training, lock
	// ----------------------------------------
	logic resyncNeed_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			taden_q <= 1'b0;
			coarse_q <= 4'h0;
			resyncNeed_q <= 1'b1;
		end else begin
			taden_q <= cfg[acc_pkg::CFG_TADEN_BIT];
			coarse_q <= regs_q[acc_pkg::REG_APDELAY][15:12];
			if (link.syncReq) begin
				resyncNeed_q <= 1'b0;
			end else if (taden_q != cfg[acc_pkg::CFG_TADEN_BIT]) begin
				resyncNeed_q <= 1'b1;
			end else if (coarse_q != regs_q[acc_pkg::REG_APDELAY][15:12]
				&& (coarse_q - regs_q[acc_pkg::REG_APDELAY][15:12] > 4'h1)
				&& (regs_q[acc_pkg::REG_APDELAY][15:12] - coarse_q > 4'h1))
			begin
				resyncNeed_q <= 1'b1;
			end
		end
	end

	logic training;
	assign training = cfg[acc_pkg::CFG_SYNCEN_BIT] && link.syncIn
		&& !ser[acc_pkg::SER_NOTRAIN_BIT];

	generate
		for (gi = 0; gi < LANES; gi++) begin : gLane
			logic [9:0] tab;
			logic [7:0] code;
			assign tab = (gi < 2) ?
				{regs_q[acc_pkg::REG_TTAB01][8*(gi%2) +: 8], 2'b00} :
				{regs_q[acc_pkg::REG_TTAB23][8*(gi%2) +: 8], 2'b00};
			assign code = sampleIn[8*gi +: 8];
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					link.laneData[10*gi +: 10] <= 10'h000;
					link.laneByteLockStatus[gi] <= 1'b0;
					link.laneGroupLockStatus[gi] <= 1'b0;
				end else begin
					link.laneByteLockStatus[gi] <= ~resyncNeed_q;
					link.laneGroupLockStatus[gi] <= ~resyncNeed_q;
					if ((calActive && ser[acc_pkg::SER_FORCE_BIT])
						|| ser[acc_pkg::SER_SERTEST_BIT]) begin
						link.laneData[10*gi +: 10] <= (gi == 0) ?
							regs_q[acc_pkg::REG_TPLANE][9:0] : tab;
					end else if (training) begin
						link.laneData[10*gi +: 10] <= 10'h2AA;
					end else if (ser[acc_pkg::SER_TPEN_BIT]) begin
						link.laneData[10*gi +: 10] <= {2'h0,
							{8{regs_q[acc_pkg::REG_TPSEQ]
							[{div4Count, 2'(gi)}]}}};
					end else begin
						link.laneData[10*gi +: 10] <= {2'h0, code};
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link.calBusy <= 1'b1;
		end else begin
			link.calBusy <= calActive;
		end
	end
endmodule

/* File: design/acc_host_ctrl.sv */
`timescale 1ns/10ps
module acc_host_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	acc_link_if.host link
);
	logic [31:0] cmd_q, wdat_q;
	logic [15:0] rdat_q;
	logic busy_q;
	logic wrPend_q;
	logic [7:0] addrPh_q;
	logic [acc_pkg::FRAME_W-1:0] shift_q;
	logic [5:0] bitCnt_q;
	logic [1:0] div_q;

	// ----------------------------------------
	// AHB-Lite slave, zero wait state
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			addrPh_q <= 8'h00;
		end else if (hready) begin
			wrPend_q <= hsel && htrans[1] && hwrite;
			addrPh_q <= haddr[7:0];
		end
	end

	logic start;
	assign start = wrPend_q && addrPh_q == acc_pkg::AHB_CMD && !busy_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= 32'h0000_0000;
			wdat_q <= 32'h0000_0000;
			link.syncIn <= 1'b0;
			link.syncReq <= 1'b0;
		end else begin
			link.syncReq <= 1'b0;
			if (start) begin
				cmd_q <= hwdata;
				link.syncReq <= hwdata[8];
				link.syncIn <= hwdata[9];
			end
			if (wrPend_q && addrPh_q == acc_pkg::AHB_WDATA) begin
				wdat_q <= hwdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				acc_pkg::AHB_CMD: hrdata <= cmd_q;
				acc_pkg::AHB_WDATA: hrdata <= wdat_q;
				acc_pkg::AHB_RDATA: hrdata <= {16'h0000, rdat_q};
				acc_pkg::AHB_STATUS: hrdata <= {22'h0, link.calBusy,
					link.laneGroupLockStatus, link.laneByteLockStatus,
					busy_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// Serial port master
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			div_q <= 2'h0;
			bitCnt_q <= '0;
			shift_q <= '0;
			rdat_q <= 16'h0000;
			link.scs <= 1'b1;
			link.sclk <= 1'b0;
			link.sdi <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
			div_q <= 2'h0;
			bitCnt_q <= '0;
			shift_q <= {hwdata[7], hwdata[3:0], wdat_q[15:0]};
			link.scs <= 1'b0;
			link.sdi <= hwdata[7];
		end else if (busy_q) begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h1) begin
				link.sclk <= 1'b1;
			end else if (div_q == 2'h3) begin
				link.sclk <= 1'b0;
				rdat_q <= {rdat_q[14:0], link.sdo};
				bitCnt_q <= bitCnt_q + 6'h01;
				shift_q <= {shift_q[acc_pkg::FRAME_W-2:0], 1'b0};
				link.sdi <= shift_q[acc_pkg::FRAME_W-2];
				if (bitCnt_q == 6'(acc_pkg::FRAME_W - 1)) begin
					busy_q <= 1'b0;
					link.scs <= 1'b1;
				end
			end
		end
	end
endmodule

/* File: design/acc_link_if.sv */
`timescale 1ns/10ps
interface acc_link_if;
	logic sclk;
	logic scs;
	logic sdi;
	logic sdo;
	logic syncIn;
	logic syncReq;
	logic [3:0] laneByteLockStatus;
	logic [3:0] laneGroupLockStatus;
	logic [39:0] laneData;
	logic calBusy;

	modport device (
		input sclk, scs, sdi, syncIn, syncReq,
		output sdo, laneByteLockStatus, laneGroupLockStatus, laneData,
		calBusy
	);
	modport host (
		output sclk, scs, sdi, syncIn, syncReq,
		input sdo, laneByteLockStatus, laneGroupLockStatus, laneData,
		calBusy
	);
endinterface

/* File: design/acc_pkg.sv */
package acc_pkg;
	// ----------------------------------------
	// Serial control port framing
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int FRAME_W = 1 + ADDR_W + DATA_W;
	localparam int SCLK_DIV = 4;
	localparam int NUM_REGS = 16;

	// ----------------------------------------
	// Device register indices
	// ----------------------------------------
	localparam logic [3:0] REG_CONFIG1 = 4'h0;
	localparam logic [3:0] REG_APDELAY = 4'h1;
	localparam logic [3:0] REG_SYNC = 4'h2;
	localparam logic [3:0] REG_CHA_FSR = 4'h3;
	localparam logic [3:0] REG_CHA_OFS = 4'h7;
	localparam logic [3:0] REG_SERIAL = 4'hB;
	localparam logic [3:0] REG_TPSEQ = 4'hC;
	localparam logic [3:0] REG_TPLANE = 4'hD;
	localparam logic [3:0] REG_TTAB01 = 4'hE;
	localparam logic [3:0] REG_TTAB23 = 4'hF;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_SEL1_LSB = 2;
	localparam int CFG_SEL2_LSB = 4;
	localparam int CFG_SEL3_LSB = 6;
	localparam int CFG_SEL4_LSB = 8;
	localparam int CFG_DC_BIT = 10;
	localparam int CFG_TERM150_BIT = 11;
	localparam int CFG_TADEN_BIT = 12;
	localparam int CFG_SYNCEN_BIT = 13;
	localparam int CFG_CAL_BIT = 14;
	localparam int SYNC_BUMP_BIT = 15;
	localparam int SER_NOTRAIN_BIT = 0;
	localparam int SER_ORPD_BIT = 1;
	localparam int SER_TPEN_BIT = 2;
	localparam int SER_SERTEST_BIT = 3;
	localparam int SER_FORCE_BIT = 4;
	localparam int OFS_SIGN_BIT = 9;

	localparam logic [15:0] TPSEQ_RESET = 16'hEA68;
	localparam int CAL_CYCLES = 64;

	// ----------------------------------------
	// AHB-Lite controller registers
	// ----------------------------------------
	localparam logic [7:0] AHB_CMD = 8'h00;
	localparam logic [7:0] AHB_WDATA = 8'h04;
	localparam logic [7:0] AHB_RDATA = 8'h08;
	localparam logic [7:0] AHB_STATUS = 8'h0C;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_DUAL,
		MODE_QUAD,
		MODE_RSVD
	} acc_mode_e;
endpackage

/* File: testbench/acc_link_sva.sv */
`timescale 1ns/10ps
module acc_link_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic scs,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic syncIn,
	input wire logic syncReq,
	input wire logic [3:0] laneByteLockStatus,
	input wire logic [3:0] laneGroupLockStatus,
	input wire logic [39:0] laneData,
	input wire logic calBusy
);
	int calCnt;
	int edgeCnt;
	logic seenSync;
	logic sclkQ;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			calCnt <= 0;
			seenSync <= 1'b0;
			sclkQ <= 1'b0;
			edgeCnt <= 0;
		end else begin
			if (calCnt < 100)
				calCnt <= calCnt + 1;
			if (syncReq)
				seenSync <= 1'b1;
			sclkQ <= sclk;
			if (scs)
				edgeCnt <= 0;
			else if (sclk && !sclkQ)
				edgeCnt <= edgeCnt + 1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_locked;
		laneByteLockStatus == 4'hF && laneGroupLockStatus == 4'hF;
	endsequence
	sequence s_sclk_period;
		sclk [*2] ##1 !sclk [*2];
	endsequence
	property p_sync_pulse;
		syncReq |=> !syncReq;
	endproperty
	property p_cal_power;
		(calCnt >= 2 && calCnt <= 60) |-> calBusy;
	endproperty
	property p_cal_done;
		calCnt == 80 |-> !calBusy;
	endproperty
	property p_lock_before_sync;
		!seenSync |-> (laneByteLockStatus == 4'h0 && laneGroupLockStatus == 4'h0);
	endproperty
	property p_lock_after_sync;
		syncReq |-> ##[1:200] s_locked;
	endproperty
	property p_frame_hold;
		$fell(scs) |-> ##1 (!scs) [*8];
	endproperty
	property p_frame_len;
		$rose(scs) |-> edgeCnt == acc_pkg::FRAME_W;
	endproperty
	property p_sclk_shape;
		$rose(sclk) |-> s_sclk_period;
	endproperty
	property p_sclk_idle;
		scs && $past(scs) |-> !sclk;
	endproperty
	property p_sdi_stable;
		sclk && $past(sclk) |-> $stable(sdi);
	endproperty
	property p_sdo_hold;
		scs && $past(scs) |-> $stable(sdo);
	endproperty

	a_sync_pulse: assert property (p_sync_pulse)
		else $error("sync request wider than one cycle");
	a_cal_power: assert property (p_cal_power)
		else $error("power-up calibration not active");
	a_cal_done: assert property (p_cal_done)
		else $error("power-up calibration too long");
	a_lock_before_sync: assert property (p_lock_before_sync)
		else $error("lane lock before sync request");
	a_lock_after_sync: assert property (p_lock_after_sync)
		else $error("lanes not locked after sync request");
	a_frame_hold: assert property (p_frame_hold)
		else $error("select released too early");
	a_frame_len: assert property (p_frame_len)
		else $error("frame bit count wrong");
	a_sclk_shape: assert property (p_sclk_shape)
		else $error("serial clock period wrong");
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock toggles while idle");
	a_sdi_stable: assert property (p_sdi_stable)
		else $error("serial data moves while clock high");
	a_sdo_hold: assert property (p_sdo_hold)
		else $error("readback data moves while deselected");
endmodule

/* File: testbench/adc_config_control_bench.sv */
`timescale 1ns/10ps
module adc_config_control_bench;
	logic mclk, rst_n, extCtrl, hwrite, hreadyout, hresp;
	logic dcCoupled, term150, overRangeEn, calActive;
	logic [3:0] pinModeSel;
	logic [31:0] haddr, hwdata, hrdata, rdVal;
	logic [1:0] htrans, adcMode, div4State, div4Count, d0;
	logic [2:0] hsize;
	logic [7:0] inputMap;
	logic [15:0] apertureDelay, cfg;
	int errCount = 0;
	int checkCount = 0;
	int cyc = 0;
	int c0;
	acc_link_if link();
	acc_host_ctrl u_acc_host_ctrl (.mclk(mclk), .rst_n(rst_n), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(link));
	acc_adc_ctrl #(.LANES(4)) u_acc_adc_ctrl (.mclk(mclk), .rst_n(rst_n),
		.extended_control_option(extCtrl), .pinModeSel(pinModeSel),
		.sampleIn(32'h0), .link(link), .adcMode(adcMode),
		.inputMap(inputMap), .dcCoupled(dcCoupled), .term150(term150),
		.apertureDelay(apertureDelay), .div4State(div4State),
		.div4Count(div4Count), .overRangeEn(overRangeEn),
		.calActive(calActive));
	acc_link_sva u_acc_link_sva (.mclk(mclk), .rst_n(rst_n),
		.sclk(link.sclk), .scs(link.scs), .sdi(link.sdi), .sdo(link.sdo),
		.syncIn(link.syncIn), .syncReq(link.syncReq),
		.laneByteLockStatus(link.laneByteLockStatus),
		.laneGroupLockStatus(link.laneGroupLockStatus),
		.laneData(link.laneData), .calBusy(link.calBusy));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= cyc + 1;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task finishTest;
		if (errCount == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdVal = hrdata;
	endtask
	task waitStatus(input logic [31:0] mask, input logic [31:0] val);
		for (int n = 0; n < 300; n++) begin
			ahb(1'b0, acc_pkg::AHB_STATUS, 32'h0);
			if ((rdVal & mask) === val)
				break;
		end
		chk("status", rdVal & mask, val);
	endtask
	task devWr(input logic [3:0] r, input logic [15:0] d);
		ahb(1'b1, acc_pkg::AHB_WDATA, {16'h0, d});
		ahb(1'b1, acc_pkg::AHB_CMD, {28'h0, r});
		waitStatus(32'h1, 32'h0);
	endtask
	task rdReg(input logic [3:0] r, input logic [15:0] exp);
		ahb(1'b1, acc_pkg::AHB_CMD, {24'h0, 4'h8, r});
		waitStatus(32'h1, 32'h0);
		ahb(1'b0, acc_pkg::AHB_RDATA, 32'h0);
		chk("readback", {16'h0, rdVal[15:0]}, {16'h0, exp});
	endtask
	task sendSync;
		ahb(1'b1, acc_pkg::AHB_CMD, 32'h0000_0180);
		waitStatus(32'h1FF, 32'h1FE);
	endtask
	task bumpStep(input logic [15:0] d, input int skip);
		@(posedge mclk);
		#1 c0 = cyc;
		d0 = div4Count;
		devWr(acc_pkg::REG_SYNC, d);
		@(posedge mclk);
		#1 chk("div4Count", div4Count, 2'(d0 + (cyc - c0) - skip));
	endtask
	task syncCap(input logic [31:0] lanes);
		ahb(1'b1, acc_pkg::AHB_CMD, 32'h0000_0280);
		#1 d0 = div4Count;
		@(posedge mclk);
		#1 chk("div4State", div4State, d0);
		chk("laneData", link.laneData[31:0], lanes);
		waitStatus(32'h1, 32'h0);
	endtask
	function automatic logic [15:0] hist(input logic [7:0] m);
		logic [15:0] h;
		h = 16'h0;
		for (int i = 0; i < 4; i++)
			h[m[2*i+:2]*4+:4] = h[m[2*i+:2]*4+:4] + 4'h1;
		return h;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		automatic logic [15:0] mapExp[3] = '{16'h0040, 16'h0220, 16'h1111};
		rst_n = 1'b0;
		extCtrl = 1'b1;
		pinModeSel = 4'h1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1 chk("calActive", calActive, 1);
		rdReg(acc_pkg::REG_TPSEQ, acc_pkg::TPSEQ_RESET);
		waitStatus(32'h200, 32'h0);
		for (int m = 0; m < 3; m++) begin
			cfg = 16'h00E4 | 16'(m) | 16'(m % 2) << 10 | 16'(m / 2) << 11;
			devWr(acc_pkg::REG_CONFIG1, cfg);
			chk("adcMode", adcMode, m);
			chk("inputMap", hist(inputMap), mapExp[m]);
			chk("dcCoupled", dcCoupled, m % 2);
			chk("term150", term150, m / 2);
			rdReg(acc_pkg::REG_CONFIG1, cfg);
		end
		extCtrl <= 1'b0;
		devWr(acc_pkg::REG_CONFIG1, 16'h0000);
		chk("adcMode", adcMode, 1);
		extCtrl <= 1'b1;
		@(posedge mclk);
		#1 chk("adcMode", adcMode, 2);
		devWr(acc_pkg::REG_CONFIG1, 16'h3000);
		devWr(acc_pkg::REG_APDELAY, 16'h5A5A);
		chk("apertureDelay", apertureDelay, 16'h5A5A);
		sendSync;
		devWr(acc_pkg::REG_APDELAY, 16'h6A5A);
		waitStatus(32'h1FE, 32'h1FE);
		devWr(acc_pkg::REG_APDELAY, 16'h8A5A);
		waitStatus(32'h1FE, 32'h0);
		sendSync;
		devWr(acc_pkg::REG_CONFIG1, 16'h2000);
		chk("apertureDelay", apertureDelay, 0);
		waitStatus(32'h1FE, 32'h0);
		sendSync;
		bumpStep(16'h8000, 1);
		bumpStep(16'h0000, 0);
		devWr(acc_pkg::REG_SERIAL, 16'h0001);
		syncCap(32'h0);
		devWr(acc_pkg::REG_SERIAL, 16'h0000);
		syncCap(32'hAAAA_AAAA);
		for (int r = 3; r < 11; r++)
			devWr(4'(r), 16'h01FF - 16'(r) | (r > 6 ? 16'h0200 : 16'h0));
		for (int r = 3; r < 11; r++)
			rdReg(4'(r), 16'h01FF - 16'(r) | (r > 6 ? 16'h0200 : 16'h0));
		devWr(acc_pkg::REG_SERIAL, 16'h0002);
		chk("overRangeEn", overRangeEn, 0);
		devWr(acc_pkg::REG_SERIAL, 16'h0000);
		chk("overRangeEn", overRangeEn, 1);
		devWr(acc_pkg::REG_TPSEQ, 16'h1357);
		devWr(acc_pkg::REG_TPLANE, 16'h03FF);
		rdReg(acc_pkg::REG_TPSEQ, 16'h1357);
		rdReg(acc_pkg::REG_TPLANE, 16'h03FF);
		devWr(acc_pkg::REG_SERIAL, 16'h0008);
		chk("laneData", link.laneData[31:0], 32'h0000_03FF);
		devWr(acc_pkg::REG_SERIAL, 16'h0010);
		devWr(acc_pkg::REG_CONFIG1, 16'h4000);
		chk("calActive", calActive, 1);
		chk("laneData", link.laneData[9:0], 32'h0000_03FF);
		waitStatus(32'h200, 32'h0);
		chk("laneData", link.laneData[9:0], 32'h0000_0000);
		rdReg(acc_pkg::REG_CONFIG1, 16'h0000);
		finishTest;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		errCount++;
		finishTest;
	end
endmodule
